// ==== logic/asi_serial_interface_config.sv ====
// Serial interface configuration register with its decoded controls
// Rules from the document
// RL1: Configuration register is 16 bits at address 0x02, all zero after reset.
// RL2: Reserved bits 15:13, 10:9, 4 and 1 ignore writes, read as zero.
// RL3: Bit 12 switches the sync pin to gating conversions while sequencing.
// RL4: Bit 11 raises drive strength of the data-out/ready pin; off by default.
// RL5: Bit 8 enables the data-out reset behaviour of the output pin.
// RL6: Bit 7 enables continuous read of the conversion data register.
// RL7: Host keeps the converter in continuous conversion before using continuous read.
// RL8: Bit 6 appends status after data on every data register read.
// RL9: Bit 5 arms the checker; any watched register change sets the error flag.
// RL10: Clearing bit 5 disarms the checker and clears its error flag.
// RL11: Configuration, data and status registers are never watched by the checker.
// RL12: Host sets registers before arming, and disarms before changing any.
// RL13: Bits 3:2 select no protection, XOR reads with CRC writes, or CRC both.
// RL14: With protection on, each register transfer grows by one check byte.
// RL15: Bit 0 selects 16-bit results; the next new result takes the length.
// RL16: With status appended the 24-bit data read widens to 32 bits.
// RL17: Checksum register holds user register XOR only while bit 5 is set.
`timescale 1ns/1ps
module asi_serial_interface_config (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	// Register access from the serial framing logic
	input  wire logic [5:0]  reg_addr_in,
	input  wire logic        reg_wr_en_in,
	input  wire logic [23:0] reg_wr_data_in,
	input  wire logic        reg_rd_en_in,
	output logic [23:0]      reg_rd_data_out,
	output logic [2:0]       reg_rd_bytes_out,
	output logic             reg_rd_valid_out,
	output logic             reg_rd_hit_out,
	// Converter state and results
	input  wire logic        adc_mode_continuous_in,
	input  wire logic        result_valid_in,
	input  wire logic [23:0] result_in,
	input  wire logic [7:0]  status_in,
	input  wire logic        data_read_done_in,
	// Checked user registers
	input  wire logic [23:0] user_regs_xor_in,
	// Decoded controls
	output logic             alternate_sync_behaviour_out,
	output logic             output_drive_boost_out,
	output logic             dout_reset_enable_out,
	output logic             continuous_result_read_out,
	output logic             status_append_out,
	output logic             short_word_select_out,
	output logic [1:0]       protection_mode_out,
	output logic             read_xor_check_out,
	output logic             write_crc_check_out,
	output logic             check_byte_out,
	// Integrity checker
	output logic [23:0]      register_checksum_out,
	output logic             reg_error_out,
	// Continuous read stream
	output logic             stream_frame_ready_out,
	output logic [31:0]      stream_frame_out,
	output logic [2:0]       stream_frame_bytes_out,
	output logic             stream_frame_short_out
);

	// Protection field decode; the undefined code 11 is taken as full CRC
	function automatic asi_pkg::asi_prot_t prot_decode(input logic [1:0] code);
		if (code == asi_pkg::PROT_CODE_NONE) begin
			prot_decode = asi_pkg::PROT_NONE; // [RL13]
		end else if (code == asi_pkg::PROT_CODE_XOR_READ) begin
			prot_decode = asi_pkg::PROT_XOR_READ; // [RL13]
		end else begin
			prot_decode = asi_pkg::PROT_CRC_BOTH; // [RL13]
		end
	endfunction : prot_decode

	// Configuration register
	logic [15:0]           if_cfg_q;
	wire  logic [15:0]     if_cfg_d;
	wire  logic            cfg_wr;
	wire  logic            cfg_rd;
	wire  logic            chk_rd;

	// Decoded fields
	wire  logic            alternate_sync_behaviour;
	wire  logic            drive_boost;
	wire  logic            dout_reset;
	wire  logic            cont_read;
	wire  logic            stat_append;
	wire  logic            reg_check;
	wire  logic            short_word;
	asi_pkg::asi_prot_t    prot_mode;

	// Read path
	logic [23:0]           rd_data_q;
	logic [2:0]            rd_bytes_q;
	logic                  rd_valid_q;
	logic                  rd_hit_q;
	wire  logic [23:0]     rd_data_d;
	wire  logic [2:0]      rd_bytes_d;
	wire  logic            rd_hit_d;
	wire  logic [2:0]      rd_chk_bytes;

	// Checker and framer results
	wire  logic [23:0]     checksum;
	wire  logic            chk_error;
	wire  logic [31:0]     frame;
	wire  logic [2:0]      frame_bytes;
	wire  logic            frame_short;

	// Continuous read sequencer
	asi_pkg::asi_cr_state_t cr_state_q;
	asi_pkg::asi_cr_state_t cr_state_d;
	logic                  result_seen_q;

	assign cfg_wr = reg_wr_en_in && (reg_addr_in == asi_pkg::ADDR_IF_CFG); // [RL1]
	assign cfg_rd = reg_addr_in == asi_pkg::ADDR_IF_CFG;
	assign chk_rd = reg_addr_in == asi_pkg::ADDR_REG_CHECKSUM;

	// Reserved positions keep their zero whatever the host sends
	assign if_cfg_d = cfg_wr ? (reg_wr_data_in[15:0] & asi_pkg::IF_CFG_WRITE_MASK) : if_cfg_q; // [RL2]

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			if_cfg_q <= asi_pkg::IF_CFG_RESET; // [RL1]
		end else begin
			if_cfg_q <= if_cfg_d;
		end
	end

	assign alternate_sync_behaviour    = if_cfg_q[asi_pkg::BIT_ALTERNATE_SYNC_BEHAVIOUR]; // [RL3]
	assign drive_boost = if_cfg_q[asi_pkg::BIT_DRIVE_BOOST]; // [RL4]
	assign dout_reset  = if_cfg_q[asi_pkg::BIT_DOUT_RESET]; // [RL5]
	assign cont_read   = if_cfg_q[asi_pkg::BIT_CONT_READ]; // [RL6]
	assign stat_append = if_cfg_q[asi_pkg::BIT_STATUS_APPEND]; // [RL8]
	assign reg_check   = if_cfg_q[asi_pkg::BIT_REG_CHECK]; // [RL9]
	assign short_word  = if_cfg_q[asi_pkg::BIT_SHORT_WORD]; // [RL15]
	assign prot_mode   = prot_decode(if_cfg_q[asi_pkg::BIT_PROT_HI:asi_pkg::BIT_PROT_LO]);

	assign alternate_sync_behaviour_out = alternate_sync_behaviour;
	assign output_drive_boost_out       = drive_boost;
	assign dout_reset_enable_out        = dout_reset;
	assign status_append_out            = stat_append;
	assign short_word_select_out        = short_word;
	assign protection_mode_out          = prot_mode;
	assign read_xor_check_out           = prot_mode == asi_pkg::PROT_XOR_READ; // [RL13]
	// Writes stay CRC protected in both enabled modes
	assign write_crc_check_out          = prot_mode != asi_pkg::PROT_NONE; // [RL13]
	assign check_byte_out               = prot_mode != asi_pkg::PROT_NONE; // [RL14]

	// Register read answers: only this block's two registers hit
	assign rd_chk_bytes = (prot_mode != asi_pkg::PROT_NONE) ? asi_pkg::BYTES_CHECK : 3'h0; // [RL14]
	assign rd_hit_d     = cfg_rd || chk_rd;
	assign rd_data_d    = cfg_rd ? {8'h00, if_cfg_q} // [RL2]
		: (chk_rd ? checksum : 24'h000000); // [RL17]
	assign rd_bytes_d   = cfg_rd ? 3'(asi_pkg::BYTES_CFG_REG + rd_chk_bytes)
		: (chk_rd ? 3'(asi_pkg::BYTES_CHECKSUM_REG + rd_chk_bytes) : 3'h0);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			rd_data_q  <= 24'h000000;
			rd_bytes_q <= 3'h0;
			rd_valid_q <= 1'b0;
			rd_hit_q   <= 1'b0;
		end else begin
			rd_valid_q <= reg_rd_en_in;
			if (reg_rd_en_in) begin
				rd_data_q  <= rd_data_d;
				rd_bytes_q <= rd_bytes_d;
				rd_hit_q   <= rd_hit_d;
			end
		end
	end

	assign reg_rd_data_out  = rd_data_q;
	assign reg_rd_bytes_out = rd_bytes_q;
	assign reg_rd_valid_out = rd_valid_q;
	assign reg_rd_hit_out   = rd_hit_q;

	// Integrity checker; the host arms it only after setting up registers [RL12]
	asi_integrity_checker u_checker (
		.mclk_in               (mclk_in),
		.sys_rst_in            (sys_rst_in),
		.armed_in              (reg_check),
		.user_regs_xor_in      (user_regs_xor_in),
		.reg_wr_en_in          (reg_wr_en_in),
		.reg_addr_in           (reg_addr_in),
		.register_checksum_out (checksum),
		.reg_error_out         (chk_error)
	);

	assign register_checksum_out = checksum;
	assign reg_error_out         = chk_error;

	// Result framing with appended status and frame length
	asi_result_framer u_framer (
		.mclk_in              (mclk_in),
		.sys_rst_in           (sys_rst_in),
		.short_word_select_in (short_word),
		.status_append_in     (stat_append),
		.check_byte_in        (prot_mode != asi_pkg::PROT_NONE),
		.result_valid_in      (result_valid_in),
		.result_in            (result_in),
		.status_in            (status_in),
		.frame_out            (frame),
		.frame_bytes_out      (frame_bytes),
		.frame_short_out      (frame_short)
	);

	// Continuous read: a frame is offered once a result arrives while conversions run continuously
	always_comb begin
		cr_state_d = cr_state_q;
		case (cr_state_q)
			asi_pkg::CR_OFF: begin
				if (cont_read) begin
					cr_state_d = asi_pkg::CR_WAIT_MODE; // [RL6]
				end
			end
			asi_pkg::CR_WAIT_MODE: begin
				if (!cont_read) begin
					cr_state_d = asi_pkg::CR_OFF;
				end else if (adc_mode_continuous_in) begin
					cr_state_d = asi_pkg::CR_WAIT_RESULT; // [RL7]
				end
			end
			asi_pkg::CR_WAIT_RESULT: begin
				if (!cont_read) begin
					cr_state_d = asi_pkg::CR_OFF;
				end else if (!adc_mode_continuous_in) begin
					cr_state_d = asi_pkg::CR_WAIT_MODE;
				end else if (result_seen_q) begin
					cr_state_d = asi_pkg::CR_PRESENT; // [RL6]
				end
			end
			asi_pkg::CR_PRESENT: begin
				if (!cont_read) begin
					cr_state_d = asi_pkg::CR_OFF;
				end else if (data_read_done_in) begin
					cr_state_d = asi_pkg::CR_WAIT_RESULT;
				end
			end
			default: begin
				cr_state_d = asi_pkg::CR_OFF;
			end
		endcase
	end

	// Result flag waits one cycle so the framer holds the new word first
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			cr_state_q    <= asi_pkg::CR_OFF;
			result_seen_q <= 1'b0;
		end else begin
			cr_state_q    <= cr_state_d;
			result_seen_q <= result_valid_in && (cr_state_q == asi_pkg::CR_WAIT_RESULT);
		end
	end

	assign continuous_result_read_out = cont_read;
	assign stream_frame_ready_out     = cr_state_q == asi_pkg::CR_PRESENT;
	assign stream_frame_out           = frame;
	assign stream_frame_bytes_out     = frame_bytes;
	assign stream_frame_short_out     = frame_short;

endmodule : asi_serial_interface_config

// ==== include/asi_pkg.sv ====
// Package of constants and types for the serial interface configuration block
package asi_pkg;

	// Register addresses
	localparam logic [5:0]  ADDR_STATUS         = 6'h00;
	localparam logic [5:0]  ADDR_IF_CFG         = 6'h02;
	localparam logic [5:0]  ADDR_REG_CHECKSUM   = 6'h03;
	localparam logic [5:0]  ADDR_DATA           = 6'h04;

	// Configuration register layout
	localparam logic [15:0] IF_CFG_RESET        = 16'h0000;
	localparam logic [15:0] IF_CFG_WRITE_MASK   = 16'h19ED;
	localparam int          BIT_ALTERNATE_SYNC_BEHAVIOUR        = 12;
	localparam int          BIT_DRIVE_BOOST     = 11;
	localparam int          BIT_DOUT_RESET      = 8;
	localparam int          BIT_CONT_READ       = 7;
	localparam int          BIT_STATUS_APPEND   = 6;
	localparam int          BIT_REG_CHECK       = 5;
	localparam int          BIT_PROT_HI         = 3;
	localparam int          BIT_PROT_LO         = 2;
	localparam int          BIT_SHORT_WORD      = 0;

	// Protection field codes
	localparam logic [1:0]  PROT_CODE_NONE      = 2'h0;
	localparam logic [1:0]  PROT_CODE_XOR_READ  = 2'h1;

	// Frame sizes in bytes
	localparam logic [2:0]  BYTES_LONG_WORD     = 3'h3;
	localparam logic [2:0]  BYTES_SHORT_WORD    = 3'h2;
	localparam logic [2:0]  BYTES_CFG_REG       = 3'h2;
	localparam logic [2:0]  BYTES_CHECKSUM_REG  = 3'h3;
	localparam logic [2:0]  BYTES_STATUS        = 3'h1;
	localparam logic [2:0]  BYTES_CHECK         = 3'h1;

	// Reset values of read-only data
	localparam logic [23:0] CHECKSUM_RESET      = 24'h000000;
	localparam logic [31:0] FRAME_RESET         = 32'h00000000;

	// Transfer protection modes
	typedef enum logic [1:0] {
		PROT_NONE,
		PROT_XOR_READ,
		PROT_CRC_BOTH
	} asi_prot_t;

	// Continuous read sequencer
	typedef enum logic [1:0] {
		CR_OFF,
		CR_WAIT_MODE,
		CR_WAIT_RESULT,
		CR_PRESENT
	} asi_cr_state_t;

endpackage : asi_pkg

// ==== logic/asi_integrity_checker.sv ====
// Register integrity checker with snapshot signature and sticky error flag
`timescale 1ns/1ps
module asi_integrity_checker (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	// Control
	input  wire logic        armed_in,
	// Monitored register view
	input  wire logic [23:0] user_regs_xor_in,
	input  wire logic        reg_wr_en_in,
	input  wire logic [5:0]  reg_addr_in,
	// Results
	output logic [23:0]      register_checksum_out,
	output logic             reg_error_out
);

	// Only configuration, checksum, data and status stay outside the watched set
	function automatic logic is_monitored(input logic [5:0] addr);
		is_monitored = (addr != asi_pkg::ADDR_IF_CFG) && (addr != asi_pkg::ADDR_DATA)
			&& (addr != asi_pkg::ADDR_STATUS) && (addr != asi_pkg::ADDR_REG_CHECKSUM); // [RL11]
	endfunction : is_monitored

	logic        armed_q;
	logic [23:0] snapshot_q;
	logic [23:0] checksum_q;
	logic        error_q;
	wire  logic  arm_edge;
	wire  logic  sig_changed;
	wire  logic  watched_write;
	wire  logic  error_set;

	assign arm_edge      = armed_in && !armed_q;
	assign sig_changed   = armed_q && (user_regs_xor_in != snapshot_q); // [RL9]
	assign watched_write = armed_q && reg_wr_en_in && is_monitored(reg_addr_in); // [RL9] [RL12]
	assign error_set     = sig_changed || watched_write;

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			armed_q    <= 1'b0;
			snapshot_q <= asi_pkg::CHECKSUM_RESET;
			checksum_q <= asi_pkg::CHECKSUM_RESET;
			error_q    <= 1'b0;
		end else begin
			armed_q    <= armed_in;
			if (arm_edge) begin
				snapshot_q <= user_regs_xor_in;
			end
			// Checksum reads zero while disarmed
			checksum_q <= armed_in ? user_regs_xor_in : asi_pkg::CHECKSUM_RESET; // [RL17]
			if (!armed_in) begin
				error_q <= 1'b0; // [RL10]
			end else if (error_set) begin
				error_q <= 1'b1; // [RL9]
			end
		end
	end

	assign register_checksum_out = checksum_q;
	assign reg_error_out         = error_q;

endmodule : asi_integrity_checker

// ==== logic/asi_result_framer.sv ====
// Conversion result framing: word length, appended status, frame length
`timescale 1ns/1ps
module asi_result_framer (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	// Configuration
	input  wire logic        short_word_select_in,
	input  wire logic        status_append_in,
	input  wire logic        check_byte_in,
	// New result from the converter
	input  wire logic        result_valid_in,
	input  wire logic [23:0] result_in,
	input  wire logic [7:0]  status_in,
	// Framed result
	output logic [31:0]      frame_out,
	output logic [2:0]       frame_bytes_out,
	output logic             frame_short_out
);

	logic        short_q;
	logic [31:0] frame_q;
	logic [2:0]  bytes_q;
	wire  logic  [2:0] word_bytes;
	wire  logic  [2:0] stat_bytes;
	wire  logic  [2:0] chk_bytes;
	wire  logic  [31:0] frame_d;

	// Length follows the setting caught with the result, so a change applies to the next one
	assign word_bytes = short_word_select_in ? asi_pkg::BYTES_SHORT_WORD : asi_pkg::BYTES_LONG_WORD; // [RL15]
	assign stat_bytes = status_append_in ? asi_pkg::BYTES_STATUS : 3'h0; // [RL16]
	assign chk_bytes  = check_byte_in ? asi_pkg::BYTES_CHECK : 3'h0; // [RL14]
	// Data left aligned, status byte right after it
	assign frame_d = short_word_select_in
		? {result_in[23:8], (status_append_in ? status_in : 8'h00), 8'h00} // [RL8]
		: {result_in, (status_append_in ? status_in : 8'h00)}; // [RL16]

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			short_q <= 1'b0;
			frame_q <= asi_pkg::FRAME_RESET;
			bytes_q <= asi_pkg::BYTES_LONG_WORD;
		end else if (result_valid_in) begin
			short_q <= short_word_select_in; // [RL15]
			frame_q <= frame_d;
			bytes_q <= 3'(word_bytes + stat_bytes + chk_bytes);
		end
	end

	assign frame_out       = frame_q;
	assign frame_bytes_out = bytes_q;
	assign frame_short_out = short_q;

endmodule : asi_result_framer

// ==== testbench/asi_host_model.sv ====
// Host model on the serial side: register accesses and stream acknowledge
`timescale 1ns/1ps
module asi_host_model (
	// Clock and device answers
	input  wire logic        mclk_in,
	input  wire logic        ready_in,
	// Register strobes and stream acknowledge
	output logic [5:0]       addr_out,
	output logic             wr_en_out,
	output logic [23:0]      wr_data_out,
	output logic             rd_en_out,
	output logic             done_out
);
	int unsigned done_delay = 0;

	initial begin
		addr_out = 6'h00;
		wr_en_out = 1'b0;
		wr_data_out = 24'h000000;
		rd_en_out = 1'b0;
		done_out = 1'b0;
	end

	// Reserved bits set only where a scenario asks for it
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge mclk_in);
		addr_out = a;
		wr_data_out = {8'h00, d};
		wr_en_out = 1'b1;
		@(negedge mclk_in);
		wr_en_out = 1'b0;
		addr_out = ~a;
		wr_data_out = ~wr_data_out;
	endtask : wr

	// Returns in the cycle where the read answer stands
	task automatic rd(input logic [5:0] a);
		@(negedge mclk_in);
		addr_out = a;
		rd_en_out = 1'b1;
		@(negedge mclk_in);
		rd_en_out = 1'b0;
		addr_out = ~a;
	endtask : rd

	// Acknowledge a streamed frame, promptly or late
	always begin
		@(negedge mclk_in);
		if (ready_in === 1'b1) begin
			repeat (done_delay) @(negedge mclk_in);
			done_out = 1'b1;
			@(negedge mclk_in);
			done_out = 1'b0;
			@(negedge mclk_in);
		end
	end
endmodule : asi_host_model

// ==== testbench/asi_sic_props.sv ====
// Checker of the configuration register block
`timescale 1ns/1ps
module asi_sic_props (
	input wire logic        mclk_in,
	input wire logic        sys_rst_in,
	input wire logic [5:0]  reg_addr_in,
	input wire logic        reg_wr_en_in,
	input wire logic [23:0] reg_wr_data_in,
	input wire logic        reg_rd_en_in,
	input wire logic [23:0] reg_rd_data_out,
	input wire logic [2:0]  reg_rd_bytes_out,
	input wire logic        reg_rd_valid_out,
	input wire logic        reg_rd_hit_out,
	input wire logic [23:0] user_regs_xor_in,
	input wire logic        alternate_sync_behaviour_out,
	input wire logic        output_drive_boost_out,
	input wire logic        dout_reset_enable_out,
	input wire logic        continuous_result_read_out,
	input wire logic        status_append_out,
	input wire logic        short_word_select_out,
	input wire logic [1:0]  protection_mode_out,
	input wire logic        check_byte_out,
	input wire logic [23:0] register_checksum_out,
	input wire logic        reg_error_out,
	input wire logic        stream_frame_ready_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	logic        armed_q;
	logic [23:0] wdata_q;
	wire         cfg_wr = reg_wr_en_in && reg_addr_in == 6'h02;

	always_ff @(posedge mclk_in) begin
		wdata_q <= reg_wr_data_in;
		if (sys_rst_in) armed_q <= 1'b0;
		else if (cfg_wr) armed_q <= reg_wr_data_in[5];
	end

	a_rd_valid_pulse: assert property (1'b1 |=> reg_rd_valid_out == $past(reg_rd_en_in))
		else $error("read answer not one cycle after strobe");
	a_reserved_read_zero: assert property (reg_rd_valid_out && $past(reg_addr_in) == 6'h02 |->
		reg_rd_hit_out && (reg_rd_data_out & 24'hFFE612) == 24'h000000) else $error("reserved bits not zero");
	a_field_outputs: assert property (cfg_wr |=> {alternate_sync_behaviour_out, output_drive_boost_out,
		dout_reset_enable_out, continuous_result_read_out, status_append_out, short_word_select_out} ==
		{wdata_q[12], wdata_q[11], wdata_q[8], wdata_q[7], wdata_q[6], wdata_q[0]}) else $error("field outputs wrong");
	a_prot_decode: assert property (cfg_wr |=> check_byte_out == (wdata_q[3:2] != 2'h0) &&
		protection_mode_out == ((wdata_q[3:2] == 2'h3) ? 2'h2 : wdata_q[3:2])) else $error("protection decode wrong");
	a_cfg_read_bytes: assert property (reg_rd_valid_out && $past(reg_addr_in) == 6'h02 |->
		reg_rd_bytes_out == ($past(check_byte_out) ? 3'h3 : 3'h2)) else $error("transfer length wrong");
	a_checksum_follow: assert property (1'b1 |=> register_checksum_out ==
		($past(armed_q) ? $past(user_regs_xor_in) : 24'h000000)) else $error("checksum wrong");
	a_error_on_write: assert property (armed_q && $past(armed_q) && reg_wr_en_in && reg_addr_in == 6'h01
		|=> reg_error_out) else $error("monitored write not flagged");
	a_error_cleared: assert property (!armed_q |=> !reg_error_out) else $error("error not cleared");
	a_excluded_quiet: assert property (!reg_error_out && reg_wr_en_in && $stable(user_regs_xor_in) &&
		(reg_addr_in == 6'h00 || reg_addr_in == 6'h02 || reg_addr_in == 6'h04) |=> !reg_error_out)
		else $error("excluded register flagged");

	c_error_raised: cover property ($rose(reg_error_out));
	c_stream_ready: cover property ($rose(stream_frame_ready_out));
	c_read_miss: cover property (reg_rd_valid_out && !reg_rd_hit_out);
endmodule : asi_sic_props

bind asi_serial_interface_config asi_sic_props chk_u (.mclk_in, .sys_rst_in, .reg_addr_in, .reg_wr_en_in,
	.reg_wr_data_in, .reg_rd_en_in, .reg_rd_data_out, .reg_rd_bytes_out, .reg_rd_valid_out, .reg_rd_hit_out,
	.user_regs_xor_in, .alternate_sync_behaviour_out, .output_drive_boost_out, .dout_reset_enable_out,
	.continuous_result_read_out, .status_append_out, .short_word_select_out, .protection_mode_out,
	.check_byte_out, .register_checksum_out, .reg_error_out, .stream_frame_ready_out);

// ==== testbench/tb_asi_serial_interface_config.sv ====
// Testbench of the configuration register block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_asi_serial_interface_config;
	logic mclk_in = 1'b0, sys_rst_in = 1'b1, adc_mode = 1'b0, res_valid = 1'b0, done, ready;
	logic [23:0] result = 24'h000000, user_xor = 24'h5A5A5A, rd_data;
	logic [7:0] status = 8'h00;
	logic [5:0] addr;
	logic wr_en, rd_en, rd_valid, hit, alt, boost, dout, cont, stat, short_w, xor_rd, crc_wr, chk_byte, err, f_short;
	logic [23:0] wr_data, csum;
	logic [2:0] rd_bytes, f_bytes;
	logic [1:0] prot;
	logic [31:0] frame;
	int failures = 0, total_checks = 0;
	always #5 mclk_in = ~mclk_in;

	asi_host_model host_u (.mclk_in(mclk_in), .ready_in(ready), .addr_out(addr), .wr_en_out(wr_en),
		.wr_data_out(wr_data), .rd_en_out(rd_en), .done_out(done));
	asi_serial_interface_config dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
		.reg_wr_en_in(wr_en), .reg_wr_data_in(wr_data), .reg_rd_en_in(rd_en), .reg_rd_data_out(rd_data),
		.reg_rd_bytes_out(rd_bytes), .reg_rd_valid_out(rd_valid), .reg_rd_hit_out(hit),
		.adc_mode_continuous_in(adc_mode), .result_valid_in(res_valid), .result_in(result), .status_in(status),
		.data_read_done_in(done), .user_regs_xor_in(user_xor), .alternate_sync_behaviour_out(alt),
		.output_drive_boost_out(boost), .dout_reset_enable_out(dout), .continuous_result_read_out(cont),
		.status_append_out(stat), .short_word_select_out(short_w), .protection_mode_out(prot),
		.read_xor_check_out(xor_rd), .write_crc_check_out(crc_wr), .check_byte_out(chk_byte),
		.register_checksum_out(csum), .reg_error_out(err), .stream_frame_ready_out(ready),
		.stream_frame_out(frame), .stream_frame_bytes_out(f_bytes), .stream_frame_short_out(f_short));

	task automatic conclude();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude

	task automatic rchk(input logic [5:0] a, input logic [23:0] d, input logic [2:0] n, input logic h);
		host_u.rd(a);
		`CHK({rd_valid, hit, rd_bytes, rd_data}, {1'b1, h, n, d})
	endtask : rchk

	task automatic waitr(input logic lvl);
		int n;
		for (n = 0; n < 50 && ready !== lvl; n++) @(negedge mclk_in);
		if (n == 50) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, ready, lvl);
			conclude();
		end
	endtask : waitr

	task automatic send(input logic [23:0] r, input logic [7:0] s);
		@(negedge mclk_in);
		{res_valid, result, status} = {1'b1, r, s};
		@(negedge mclk_in);
		{res_valid, result, status} = {1'b0, ~r, ~s};
	endtask : send

	task automatic t_reset();
		rchk(6'h02, 24'h000000, 3'h2, 1'b1);
		rchk(6'h03, 24'h000000, 3'h3, 1'b1);
		rchk(6'h05, 24'h000000, 3'h0, 1'b0);
	endtask : t_reset

	task automatic t_fields();
		int b[6] = '{12, 11, 8, 7, 6, 0};
		for (int i = 0; i < 6; i++) begin
			host_u.wr(6'h02, 16'h0001 << b[i]);
			`CHK({alt, boost, dout, cont, stat, short_w}, 6'b100000 >> i)
			rchk(6'h02, 24'h000001 << b[i], 3'h2, 1'b1);
		end
		host_u.wr(6'h02, 16'hFFFF);
		rchk(6'h02, 24'h0019ED, 3'h3, 1'b1);
		`CHK(prot, 2'h2)
		host_u.wr(6'h02, 16'h0000);
	endtask : t_fields

	task automatic t_prot();
		for (int c = 0; c < 3; c++) begin
			host_u.wr(6'h02, 16'(c << 2));
			`CHK({prot, xor_rd, crc_wr, chk_byte}, {2'(c), c == 1, c != 0, c != 0})
			rchk(6'h02, 24'(c << 2), (c != 0) ? 3'h3 : 3'h2, 1'b1);
		end
		host_u.wr(6'h02, 16'h0000);
	endtask : t_prot

	task automatic t_checker();
		host_u.wr(6'h01, 16'h1234);
		host_u.wr(6'h02, 16'h0020);
		rchk(6'h03, 24'h5A5A5A, 3'h3, 1'b1);
		host_u.wr(6'h04, 16'h0F0F);
		host_u.wr(6'h00, 16'h00FF);
		host_u.wr(6'h02, 16'h0020);
		@(negedge mclk_in);
		`CHK(err, 1'b0)
		host_u.wr(6'h01, 16'h0055);
		@(negedge mclk_in);
		`CHK(err, 1'b1)
		host_u.wr(6'h02, 16'h0000);
		@(negedge mclk_in);
		`CHK({err, csum}, 25'h0000000)
		host_u.wr(6'h02, 16'h0020);
		repeat (2) @(negedge mclk_in);
		user_xor = 24'h5A5A5B;
		repeat (2) @(negedge mclk_in);
		`CHK(err, 1'b1)
		host_u.wr(6'h02, 16'h0000);
		@(negedge mclk_in);
		`CHK(err, 1'b0)
	endtask : t_checker

	task automatic t_stream();
		host_u.wr(6'h02, 16'h00C0);
		adc_mode = 1'b1;
		// Sequencer takes two cycles to reach the wait for a result
		repeat (2) @(negedge mclk_in);
		send(24'hABCDEF, 8'h81);
		waitr(1'b1);
		`CHK({frame, f_bytes, f_short}, {32'hABCDEF81, 3'h4, 1'b0})
		waitr(1'b0);
		host_u.wr(6'h02, 16'h00C1);
		host_u.done_delay = 4;
		send(24'h123456, 8'h02);
		waitr(1'b1);
		`CHK({frame, f_bytes, f_short}, {32'h12340200, 3'h3, 1'b1})
		waitr(1'b0);
		host_u.wr(6'h02, 16'h0041);
		send(24'h654321, 8'h03);
		repeat (4) @(negedge mclk_in);
		`CHK(ready, 1'b0)
	endtask : t_stream

	initial begin
		repeat (12) @(negedge mclk_in);
		sys_rst_in = 1'b0;
		t_reset();
		t_fields();
		t_prot();
		t_checker();
		t_stream();
		// Mid-run reset must clear every configuration bit again
		host_u.wr(6'h02, 16'hFFFF);
		@(negedge mclk_in);
		sys_rst_in = 1'b1;
		repeat (2) @(negedge mclk_in);
		sys_rst_in = 1'b0;
		t_reset();
		conclude();
	end
endmodule : tb_asi_serial_interface_config
